// file: hw/radc_pkg.sv
package radc_pkg;
  // address layout: top | mid | low | column | block
  localparam int ADDR_W = 13;
  localparam int TOP_POS = 12;
  localparam int MID_LSB = 9;
  localparam int LOW_LSB = 6;
  localparam int COL_LSB = 3;
  localparam int BLK_LSB = 0;
  localparam int FLD_W = 3;

  localparam logic [4:0] WL_LAST_INTL = 5'h02;
  localparam logic [4:0] WL_LAST_NEIGH = 5'h15;
  localparam logic [4:0] WL_LAST_DISC = 5'h01;
  localparam logic [4:0] WL_MID_END = 5'h07;
  localparam logic [4:0] WL_LOW_END = 5'h0E;
  localparam logic [2:0] COL_LAST = 3'h7;

  // interleaved column order for the first 24 reads
  localparam logic [23:0] COL_ORDER = {3'h7, 3'h0, 3'h4, 3'h3, 3'h6, 3'h1, 3'h2, 3'h5};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ISSUE = 4'h2,
    ST_WAIT = 4'h4,
    ST_DONE = 4'h8
  } radc_state_e;

  typedef enum logic [2:0] {
    PH_INTL = 3'h1,
    PH_NEIGH = 3'h2,
    PH_DISC = 3'h4
  } radc_phase_e;
endpackage

// file: hw/radc_addr_gen.sv
`timescale 1ns/10ps
module radc_addr_gen
  import radc_pkg::*;
(
  input wire logic [ADDR_W-1:0] victim_address,
  input wire radc_phase_e phase,
  input wire logic [4:0] wl_idx,
  input wire logic [2:0] col_idx,
  output logic [ADDR_W-1:0] rd_addr
);
  logic top_row_decoder_bit;
  logic [FLD_W-1:0] mid_row_decoder_field;
  logic [FLD_W-1:0] low_row_decoder_field;
  logic [FLD_W-1:0] word_column_field;
  logic [FLD_W-1:0] blk;
  logic [FLD_W-1:0] step;

  always_comb
  begin
    top_row_decoder_bit = victim_address[TOP_POS];
    mid_row_decoder_field = victim_address[MID_LSB +: FLD_W];
    low_row_decoder_field = victim_address[LOW_LSB +: FLD_W];
    blk = victim_address[BLK_LSB +: FLD_W];
    word_column_field = col_idx;
    step = wl_idx[2:0];
    case (phase)
      PH_INTL:
      begin
        word_column_field = COL_ORDER[col_idx*FLD_W +: FLD_W];
        if (wl_idx == 5'h00)
        begin
          top_row_decoder_bit = ~top_row_decoder_bit;
          mid_row_decoder_field = ~mid_row_decoder_field;
          low_row_decoder_field = ~low_row_decoder_field;
        end
        else if (wl_idx == WL_LAST_INTL)
        begin
          blk = ~blk;
        end
      end
      PH_NEIGH:
      begin
        if (wl_idx == 5'h00)
        begin
          top_row_decoder_bit = ~top_row_decoder_bit;
        end
        else if (wl_idx <= WL_MID_END)
        begin
          mid_row_decoder_field = mid_row_decoder_field + step;
        end
        else if (wl_idx <= WL_LOW_END)
        begin
          low_row_decoder_field = low_row_decoder_field + 3'(wl_idx - WL_MID_END);
        end
        else
        begin
          blk = blk + 3'(wl_idx - WL_LOW_END);
        end
      end
      PH_DISC:
      begin
        // complement one field of the complementary address
        top_row_decoder_bit = ~top_row_decoder_bit;
        if (wl_idx == 5'h00)
        begin
          mid_row_decoder_field = ~mid_row_decoder_field;
        end
        else
        begin
          low_row_decoder_field = ~low_row_decoder_field;
        end
      end
      default:
      begin
        word_column_field = col_idx;
      end
    endcase
    rd_addr = {top_row_decoder_bit, mid_row_decoder_field, low_row_decoder_field,
               word_column_field, blk};
  end
endmodule

// file: hw/radc_seq.sv
`timescale 1ns/10ps
// Notes on behaviour
// - corrected single-bit error starts test
// - derive readback locations from victim
// - read each location, check its ECC
// - fields: top 1, mid/low/column/block 3
// - 24 interleaved reads, fixed column order
// - add single-field neighbour word-lines and blocks
// - at least four other-block reads
// - uncorrectable error means addressing fault
// - more errors than buffer depth: fault
// - multiple errors on victim word-line: suspect
// - new single-bit error reruns with new victim
// - extra step separates upset from fault
// - read complement-low and complement-mid word-lines
// - complementary address inverts all decoder bits
// - several corrections there: likely addressing fault
module radc_seq
  import radc_pkg::*;
#(
  parameter int EBU_DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sbe_valid,
  input wire logic [ADDR_W-1:0] sbe_addr,
  output logic rd_req_r,
  output logic [ADDR_W-1:0] rd_addr_r,
  input wire logic rd_resp,
  input wire logic rd_sbe,
  input wire logic rd_dbe,
  output logic busy_r,
  output logic done_r,
  output logic fault_r,
  output logic upset_r
);
  localparam int CNT_W = $clog2(EBU_DEPTH + 2);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(EBU_DEPTH);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  if (EBU_DEPTH < 1)
  begin : g_bad_depth
    $error("EBU_DEPTH must be at least 1");
  end

  radc_state_e state_r, state_nxt;
  radc_phase_e phase_r, phase_nxt;
  logic [4:0] wl_r, wl_nxt;
  logic [2:0] col_r, col_nxt;
  logic [ADDR_W-1:0] victim_r, victim_nxt;
  logic [ADDR_W-1:0] rd_addr_nxt, gen_addr;
  logic rd_req_nxt, busy_nxt, done_nxt, fault_nxt, upset_nxt;
  logic [CNT_W-1:0] sbe_cnt_r, sbe_cnt_nxt;
  logic [1:0] disc_cnt_r, disc_cnt_nxt;
  logic multi_r, multi_nxt;
  logic pend_r, pend_nxt;
  logic [ADDR_W-1:0] pend_addr_r, pend_addr_nxt;

  function automatic logic [4:0] wl_last(input radc_phase_e ph);
    case (ph)
      PH_INTL: wl_last = WL_LAST_INTL;
      PH_NEIGH: wl_last = WL_LAST_NEIGH;
      PH_DISC: wl_last = WL_LAST_DISC;
      default: wl_last = WL_LAST_INTL;
    endcase
  endfunction

  function automatic logic same_wordline(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] b);
    same_wordline = (a[ADDR_W-1:LOW_LSB] == b[ADDR_W-1:LOW_LSB]) &&
                    (a[BLK_LSB +: FLD_W] == b[BLK_LSB +: FLD_W]);
  endfunction

  radc_addr_gen u_gen (
    .victim_address(victim_r),
    .phase(phase_r),
    .wl_idx(wl_r),
    .col_idx(col_r),
    .rd_addr(gen_addr)
  );

  always_comb
  begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    wl_nxt = wl_r;
    col_nxt = col_r;
    victim_nxt = victim_r;
    rd_addr_nxt = rd_addr_r;
    rd_req_nxt = 1'b0;
    done_nxt = done_r;
    fault_nxt = fault_r;
    upset_nxt = upset_r;
    sbe_cnt_nxt = sbe_cnt_r;
    disc_cnt_nxt = disc_cnt_r;
    multi_nxt = multi_r;
    pend_nxt = pend_r;
    pend_addr_nxt = pend_addr_r;
    case (state_r)
      ST_IDLE, ST_DONE:
      begin
        if (sbe_valid)
        begin
          state_nxt = ST_ISSUE;
          phase_nxt = PH_INTL;
          victim_nxt = sbe_addr;
          wl_nxt = '0;
          col_nxt = '0;
          done_nxt = 1'b0;
          fault_nxt = 1'b0;
          upset_nxt = 1'b0;
          sbe_cnt_nxt = '0;
          disc_cnt_nxt = '0;
          multi_nxt = 1'b0;
          pend_nxt = 1'b0;
        end
      end
      ST_ISSUE:
      begin
        rd_req_nxt = 1'b1;
        rd_addr_nxt = gen_addr;
        state_nxt = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (rd_resp)
        begin
          state_nxt = ST_ISSUE;
          if (rd_sbe && sbe_cnt_r != CNT_MAX)
          begin
            sbe_cnt_nxt = sbe_cnt_r + 1'b1;
          end
          if (rd_sbe && phase_r == PH_DISC && disc_cnt_r != 2'h3)
          begin
            disc_cnt_nxt = disc_cnt_r + 1'b1;
          end
          if (rd_sbe && phase_r != PH_DISC && rd_addr_r != victim_r &&
              same_wordline(rd_addr_r, victim_r))
          begin
            multi_nxt = 1'b1;
          end
          if (rd_sbe && phase_r != PH_DISC && rd_addr_r != victim_r && !pend_r)
          begin
            pend_nxt = 1'b1;
            pend_addr_nxt = rd_addr_r;
          end
          if (wl_r != wl_last(phase_r))
          begin
            wl_nxt = wl_r + 1'b1;
          end
          else
          begin
            wl_nxt = '0;
            if (col_r != COL_LAST)
            begin
              col_nxt = col_r + 1'b1;
            end
            else
            begin
              col_nxt = '0;
              if (phase_r == PH_INTL)
              begin
                phase_nxt = PH_NEIGH;
              end
              else if (phase_r == PH_NEIGH && multi_nxt)
              begin
                phase_nxt = PH_DISC;
              end
              else if (phase_r == PH_DISC && disc_cnt_nxt > 2'h1)
              begin
                fault_nxt = 1'b1;
                state_nxt = ST_DONE;
              end
              else
              begin
                if (phase_r == PH_DISC)
                begin
                  upset_nxt = 1'b1;
                end
                if (pend_nxt)
                begin
                  victim_nxt = pend_addr_nxt;
                  phase_nxt = PH_INTL;
                  pend_nxt = 1'b0;
                  multi_nxt = 1'b0;
                  disc_cnt_nxt = '0;
                end
                else
                begin
                  state_nxt = ST_DONE;
                end
              end
            end
          end
          if (rd_dbe || sbe_cnt_nxt > DEPTH_C)
          begin
            fault_nxt = 1'b1;
            state_nxt = ST_DONE;
          end
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (state_nxt == ST_DONE)
    begin
      done_nxt = 1'b1;
    end
    if (fault_nxt)
    begin
      upset_nxt = 1'b0;
    end
    busy_nxt = (state_nxt == ST_ISSUE) || (state_nxt == ST_WAIT);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      phase_r <= PH_INTL;
      wl_r <= '0;
      col_r <= '0;
      victim_r <= '0;
      rd_addr_r <= '0;
      rd_req_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      upset_r <= 1'b0;
      sbe_cnt_r <= '0;
      disc_cnt_r <= '0;
      multi_r <= 1'b0;
      pend_r <= 1'b0;
      pend_addr_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      wl_r <= wl_nxt;
      col_r <= col_nxt;
      victim_r <= victim_nxt;
      rd_addr_r <= rd_addr_nxt;
      rd_req_r <= rd_req_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      fault_r <= fault_nxt;
      upset_r <= upset_nxt;
      sbe_cnt_r <= sbe_cnt_nxt;
      disc_cnt_r <= disc_cnt_nxt;
      multi_r <= multi_nxt;
      pend_r <= pend_nxt;
      pend_addr_r <= pend_addr_nxt;
    end
  end
endmodule

// file: testbench/radc_seq_monitor.sv
`timescale 1ns/10ps
module radc_seq_monitor
  import radc_pkg::*;
#(
  parameter int EBU_DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sbe_valid,
  input wire logic [ADDR_W-1:0] sbe_addr,
  input wire logic rd_req_r,
  input wire logic [ADDR_W-1:0] rd_addr_r,
  input wire logic rd_resp,
  input wire logic rd_sbe,
  input wire logic rd_dbe,
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic fault_r,
  input wire logic upset_r
);
  logic start;
  logic err_r;
  logic [8:0] n_rd_r;
  logic [8:0] n_sbe_r;
  logic [ADDR_W-1:0] vic_r;
  assign start = sbe_valid && !busy_r && !rst;
  // counts span iterations, cleared only by reset or a fresh start
  always_ff @(posedge core_clk)
  begin
    if (start)
      vic_r <= sbe_addr;
    if (rst || start)
    begin
      n_rd_r <= 9'h000;
      n_sbe_r <= 9'h000;
      err_r <= 1'b0;
    end
    else
    begin
      n_rd_r <= n_rd_r + 9'(rd_req_r);
      n_sbe_r <= n_sbe_r + 9'(busy_r && rd_resp && rd_sbe);
      err_r <= err_r || (busy_r && rd_resp && (rd_sbe || rd_dbe));
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_req_pulse: assert property (rd_req_r |=> !rd_req_r)
    else $error("read request too long");
  a_start_busy: assert property (start |=> busy_r && !done_r)
    else $error("start not taken");
  a_first_read: assert property ($past(start, 2) |-> rd_req_r
    && rd_addr_r == {~vic_r[12:6], 3'h5, vic_r[2:0]}) else $error("wrong first read");
  a_resp_next: assert property (busy_r && rd_resp |=> done_r or (1'b1 ##1 rd_req_r))
    else $error("no follow-up to response");
  a_dbe_fault: assert property (busy_r && rd_resp && rd_dbe |=> done_r && fault_r)
    else $error("uncorrectable not flagged");
  a_sbe_limit: assert property (busy_r && rd_resp && rd_sbe
    && n_sbe_r == 9'(EBU_DEPTH) |=> done_r && fault_r) else $error("error count not flagged");
  a_upset_pass: assert property (upset_r |-> !fault_r && (done_r || busy_r))
    else $error("upset with fault");
  a_clean_count: assert property ($rose(done_r) && !err_r |-> n_rd_r == 9'h0C8)
    else $error("clean run read count");
endmodule

bind radc_seq radc_seq_monitor #(.EBU_DEPTH(EBU_DEPTH)) mon_u (.core_clk, .rst, .sbe_valid,
  .sbe_addr, .rd_req_r, .rd_addr_r, .rd_resp, .rd_sbe, .rd_dbe, .busy_r, .done_r, .fault_r,
  .upset_r);

// file: testbench/radc_ram_model.sv
`timescale 1ns/10ps
module radc_ram_model
  import radc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rd_req_r,
  input wire logic [ADDR_W-1:0] rd_addr_r,
  input wire logic [1:0] lat,
  input wire logic [ADDR_W-1:0] cfg [6],
  output logic rd_resp,
  output logic rd_sbe,
  output logic rd_dbe
);
  logic pend = 1'b0;
  logic [1:0] wait_n;
  logic [ADDR_W-1:0] a;
  initial
  begin
    rd_resp = 1'b0;
    rd_sbe = 1'b0;
    rd_dbe = 1'b0;
  end
  always @(posedge core_clk)
  begin
    #1;
    rd_resp = 1'b0;
    // flags carry nothing outside a response, so keep them moving
    rd_sbe = ~rd_sbe;
    rd_dbe = ~rd_dbe;
    if (rst)
      pend = 1'b0;
    else if (rd_req_r)
    begin
      pend = 1'b1;
      wait_n = lat;
      a = rd_addr_r;
    end
    else if (pend && wait_n != 2'h0)
      wait_n = wait_n - 2'h1;
    else if (pend)
    begin
      pend = 1'b0;
      rd_resp = 1'b1;
      rd_sbe = (a & cfg[0]) == cfg[1] || (a & cfg[2]) == cfg[3];
      rd_dbe = (a & cfg[4]) == cfg[5];
    end
  end
endmodule

// file: testbench/test_ram_address_decoder_check.sv
`timescale 1ns/10ps
module test_ram_address_decoder_check;
  import radc_pkg::*;
  localparam logic [ADDR_W-1:0] N0 = 13'h0000;
  localparam logic [ADDR_W-1:0] N1 = 13'h0001;
  localparam logic [ADDR_W-1:0] FF = 13'h1FFF;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sbe_valid = 1'b0;
  logic [ADDR_W-1:0] sbe_addr = 13'h0000;
  logic rd_req_r, rd_resp, rd_sbe, rd_dbe, busy_r, done_r, fault_r, upset_r;
  logic [ADDR_W-1:0] rd_addr_r, v, e;
  logic [ADDR_W-1:0] cfg [6];
  logic [1:0] lat = 2'h0;
  logic [ADDR_W-1:0] seen [$];
  logic [2:0] cols [8] = '{3'h5, 3'h2, 3'h1, 3'h6, 3'h3, 3'h4, 3'h0, 3'h7};
  int n_fail = 0;
  int tests_run = 0;
  int ob, tf, d3;
  always #20 core_clk = ~core_clk;
  radc_seq dut_u (.core_clk, .rst, .sbe_valid, .sbe_addr, .rd_req_r, .rd_addr_r, .rd_resp,
    .rd_sbe, .rd_dbe, .busy_r, .done_r, .fault_r, .upset_r);
  radc_ram_model ram_u (.core_clk, .rst, .rd_req_r, .rd_addr_r, .lat, .cfg, .rd_resp,
    .rd_sbe, .rd_dbe);
  always @(posedge core_clk)
    if (rd_req_r === 1'b1)
      seen.push_back(rd_addr_r);
  function automatic logic [ADDR_W-1:0] exp1(input int i);
    logic [2:0] c;
    c = cols[i / 3];
    if (i % 3 == 0)
      return {~v[12:6], c, v[2:0]};
    return (i % 3 == 1) ? {v[12:6], c, v[2:0]} : {v[12:6], c, ~v[2:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic [ADDR_W-1:0] m1, v1, m2, v2, md, vd);
    int i;
    cfg = '{m1, v1, m2, v2, md, vd};
    lat = 2'($urandom_range(3));
    seen = {};
    sbe_addr = v;
    sbe_valid = 1'b1;
    @(posedge core_clk);
    #1 sbe_valid = 1'b0;
    repeat (4) @(posedge core_clk);
    // a start while running must be ignored
    #1 sbe_valid = 1'b1;
    sbe_addr = ~v;
    @(posedge core_clk);
    #1 sbe_valid = 1'b0;
    for (i = 0; i < 9000 && done_r !== 1'b1; i++)
      @(posedge core_clk);
    #1;
    if (done_r !== 1'b1)
    begin
      chk(0, 1);
      stop_test();
    end
    ob = 0;
    tf = 0;
    d3 = 0;
    foreach (seen[k])
    begin
      ob += int'(seen[k][12:6] == v[12:6] && seen[k][2:0] != v[2:0]);
      tf += int'(seen[k][12:6] == {~v[12], v[11:6]});
      d3 += int'(seen[k][12:6] == {~v[12:9], v[8:6]});
    end
  endtask
  initial
  begin
    void'($urandom(32'hD18F5E6B));
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    chk({busy_r, done_r, fault_r, upset_r, rd_req_r}, 0);
    repeat (2)
    begin
      v = 13'($urandom);
      run(N0, N1, N0, N1, N0, N1);
      chk({fault_r, upset_r}, 0);
      chk(seen.size(), 200);
      chk(ob, 64);
      chk(tf, 8);
      for (int i = 0; i < 24; i++)
        chk(seen[i], exp1(i));
    end
    v = 13'($urandom);
    run(N0, N1, N0, N1, FF, exp1(19));
    chk(fault_r, 1);
    chk(seen.size(), 20);
    run(13'h0007, {10'h000, ~v[2:0]}, N0, N1, N0, N1);
    chk(fault_r, 1);
    e = {v[12:6], v[5:3] ^ 3'h1, v[2:0]};
    run(FF, e, N0, N1, N0, N1);
    chk({fault_r, upset_r}, 1);
    chk(d3 >= 8, 1);
    chk(seen.size(), 416);
    run(FF, e, 13'h1FF7, {~v[12:9], v[8:6], 3'h0, v[2:0]}, N0, N1);
    chk({fault_r, upset_r}, 2);
    chk(seen.size(), 216);
    stop_test();
  end
endmodule
